/* rtl/amd_pkg.sv */
package amd_pkg;

	// *****************************************************************
	// Widths and fixed codes
	// *****************************************************************
	localparam int            AMD_AW       = 16;
	localparam int            AMD_DW       = 8;
	localparam logic [7:0]    AMD_PRE_Y    = 8'h90;
	localparam logic [7:0]    AMD_PRE_YIND = 8'h91;
	localparam logic [7:0]    AMD_PRE_IND  = 8'h92;
	localparam logic [3:0]    AMD_SHORT_ONLY_MIN = 4'hA;
	localparam logic [15:0]   AMD_RESET_PC = 16'h0000;
	localparam logic [7:0]    AMD_PAGE0_HI = 8'h00;
	localparam logic [15:0]   AMD_PC_STEP  = 16'h0001;
	localparam logic [1:0]    AMD_ONE      = 2'h1;
	localparam logic [1:0]    AMD_TWO      = 2'h2;

	// *****************************************************************
	// Opcode mode field, opcode bits 7:4, before any prebyte
	// *****************************************************************
	localparam logic [3:0]    AMD_F_INH    = 4'h0;
	localparam logic [3:0]    AMD_F_IMM    = 4'h1;
	localparam logic [3:0]    AMD_F_DIR_S  = 4'h2;
	localparam logic [3:0]    AMD_F_DIR_L  = 4'h3;
	localparam logic [3:0]    AMD_F_IDX_0  = 4'h4;
	localparam logic [3:0]    AMD_F_IDX_S  = 4'h5;
	localparam logic [3:0]    AMD_F_IDX_L  = 4'h6;
	localparam logic [3:0]    AMD_F_REL_D  = 4'h7;
	localparam logic [3:0]    AMD_F_BIT_D  = 4'h8;
	localparam logic [3:0]    AMD_F_BIT_DR = 4'hA;

	// *****************************************************************
	// Types
	// *****************************************************************
	typedef enum logic [4:0] {
		AMD_M_INH    = 5'h00,
		AMD_M_IMM    = 5'h01,
		AMD_M_DIR_S  = 5'h02,
		AMD_M_DIR_L  = 5'h03,
		AMD_M_IDX_0  = 5'h04,
		AMD_M_IDX_S  = 5'h05,
		AMD_M_IDX_L  = 5'h06,
		AMD_M_REL_D  = 5'h07,
		AMD_M_BIT_D  = 5'h08,
		AMD_M_BIT_DR = 5'h0A,
		AMD_M_IND_S  = 5'h0B,
		AMD_M_IND_L  = 5'h0C,
		AMD_M_IIX_S  = 5'h0D,
		AMD_M_IIX_L  = 5'h0E,
		AMD_M_REL_I  = 5'h0F,
		AMD_M_BIT_I  = 5'h10,
		AMD_M_BIT_IR = 5'h11,
		AMD_M_ILL    = 5'h1F
	} amd_mode_e;

	typedef enum logic [1:0] {
		AMD_P_NONE = 2'h0,
		AMD_P_Y    = 2'h1,
		AMD_P_IND  = 2'h2,
		AMD_P_YIND = 2'h3
	} amd_pre_e;

	typedef struct packed {
		amd_mode_e  mode;
		logic       use_y;
		logic       is_long;
		logic       illegal;
		logic [1:0] n_bytes;
		logic [1:0] ptr_bytes;
	} amd_dec_s;

	typedef struct packed {
		amd_mode_e   mode;
		amd_pre_e    pre;
		logic        use_y;
		logic        is_long;
		logic        illegal;
		logic [7:0]  opcode;
		logic [2:0]  length;
		logic [7:0]  operand;
		logic [15:0] ea;
		logic [15:0] rel_target;
		logic [15:0] next_pc;
	} amd_res_s;

	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} amd_mreq_s;

endpackage

/* rtl/amd_mode_classify.sv */
module amd_mode_classify
	import amd_pkg::*;
(
	// Decode input
	input  wire amd_pkg::amd_pre_e pre,
	input  wire logic [7:0]        opcode,
	// Decode result
	output amd_pkg::amd_dec_s      dec
);

	// *****************************************************************
	// Mode and length from the opcode, then the prebyte rewrite
	// *****************************************************************
	always_comb
	begin
		dec = '0;
		case (opcode[7:4])
			AMD_F_INH:    dec.mode = AMD_M_INH;
			AMD_F_IMM:
			begin
				dec.mode    = AMD_M_IMM;
				dec.n_bytes = AMD_ONE;
			end
			AMD_F_DIR_S:
			begin
				dec.mode    = AMD_M_DIR_S;
				dec.n_bytes = AMD_ONE;
			end
			AMD_F_DIR_L:
			begin
				dec.mode    = AMD_M_DIR_L;
				dec.n_bytes = AMD_TWO;
			end
			AMD_F_IDX_0:  dec.mode = AMD_M_IDX_0;
			AMD_F_IDX_S:
			begin
				dec.mode    = AMD_M_IDX_S;
				dec.n_bytes = AMD_ONE;
			end
			AMD_F_IDX_L:
			begin
				dec.mode    = AMD_M_IDX_L;
				dec.n_bytes = AMD_TWO;
			end
			AMD_F_REL_D:
			begin
				dec.mode    = AMD_M_REL_D;
				dec.n_bytes = AMD_ONE;
			end
			AMD_F_BIT_D:
			begin
				dec.mode    = AMD_M_BIT_D;
				dec.n_bytes = AMD_ONE;
			end
			AMD_F_BIT_DR:
			begin
				dec.mode    = AMD_M_BIT_DR;
				dec.n_bytes = AMD_TWO;
			end
			default:
			begin
				dec.mode    = AMD_M_ILL;
				dec.illegal = 1'b1;
			end
		endcase
		case (pre)
			AMD_P_Y:
			begin
				case (dec.mode)
					AMD_M_INH, AMD_M_IMM, AMD_M_DIR_S, AMD_M_DIR_L,
					AMD_M_IDX_0, AMD_M_IDX_S, AMD_M_IDX_L:
						dec.use_y = 1'b1;
					default: dec.illegal = 1'b1;
				endcase
			end
			AMD_P_IND:
			begin
				dec.n_bytes   = AMD_ONE;
				dec.ptr_bytes = AMD_ONE;
				case (dec.mode)
					AMD_M_DIR_S: dec.mode = AMD_M_IND_S;
					AMD_M_DIR_L:
					begin
						dec.mode      = AMD_M_IND_L;
						dec.ptr_bytes = AMD_TWO;
					end
					AMD_M_IDX_S: dec.mode = AMD_M_IIX_S;
					AMD_M_IDX_L:
					begin
						dec.mode      = AMD_M_IIX_L;
						dec.ptr_bytes = AMD_TWO;
					end
					AMD_M_REL_D: dec.mode = AMD_M_REL_I;
					AMD_M_BIT_D: dec.mode = AMD_M_BIT_I;
					AMD_M_BIT_DR:
					begin
						dec.mode    = AMD_M_BIT_IR;
						dec.n_bytes = AMD_TWO;
					end
					default:
					begin
						dec.illegal   = 1'b1;
						dec.n_bytes   = 2'h0;
						dec.ptr_bytes = 2'h0;
					end
				endcase
			end
			AMD_P_YIND:
			begin
				dec.use_y     = 1'b1;
				dec.n_bytes   = AMD_ONE;
				dec.ptr_bytes = AMD_ONE;
				case (dec.mode)
					AMD_M_IDX_S: dec.mode = AMD_M_IIX_S;
					AMD_M_IDX_L:
					begin
						dec.mode      = AMD_M_IIX_L;
						dec.ptr_bytes = AMD_TWO;
					end
					default:
					begin
						dec.illegal   = 1'b1;
						dec.n_bytes   = 2'h0;
						dec.ptr_bytes = 2'h0;
					end
				endcase
			end
			default: ;
		endcase
		dec.is_long = (dec.mode == AMD_M_DIR_L) || (dec.mode == AMD_M_IDX_L)
			|| (dec.mode == AMD_M_IND_L) || (dec.mode == AMD_M_IIX_L);
		// Long forms are refused for the short-only operation group.
		if (dec.is_long && (opcode[3:0] >= AMD_SHORT_ONLY_MIN))
			dec.illegal = 1'b1;
	end

endmodule

/* rtl/amd_ea_calc.sv */
module amd_ea_calc
	import amd_pkg::*;
(
	// Decoded mode and fetched bytes
	input  wire amd_pkg::amd_mode_e mode,
	input  wire logic [7:0]         arg1,
	input  wire logic [7:0]         arg2,
	input  wire logic [7:0]         ptr1,
	input  wire logic [7:0]         ptr2,
	input  wire logic [7:0]         index,
	input  wire logic [15:0]        next_pc,
	// Address results
	output logic [15:0]             ea,
	output logic [15:0]             rel_target
);

	logic [15:0] arg_word;
	logic [15:0] ptr_word;
	logic [7:0]  rel_off;

	// *****************************************************************
	// Effective address and relative target
	// *****************************************************************
	always_comb
	begin
		arg_word = {arg1, arg2};
		ptr_word = {ptr1, ptr2};
		case (mode)
			AMD_M_DIR_S, AMD_M_BIT_D, AMD_M_BIT_DR:
				ea = {AMD_PAGE0_HI, arg1};
			AMD_M_DIR_L:  ea = arg_word;
			AMD_M_IDX_0:  ea = {AMD_PAGE0_HI, index};
			AMD_M_IDX_S:
				ea = {AMD_PAGE0_HI, arg1} + {AMD_PAGE0_HI, index};
			AMD_M_IDX_L:  ea = arg_word + {AMD_PAGE0_HI, index};
			AMD_M_IND_S, AMD_M_BIT_I, AMD_M_BIT_IR:
				ea = {AMD_PAGE0_HI, ptr1};
			AMD_M_IND_L:  ea = ptr_word;
			AMD_M_IIX_S:
				ea = {AMD_PAGE0_HI, ptr1} + {AMD_PAGE0_HI, index};
			AMD_M_IIX_L:  ea = ptr_word + {AMD_PAGE0_HI, index};
			default:      ea = 16'h0000;
		endcase
		case (mode)
			AMD_M_REL_D:                rel_off = arg1;
			AMD_M_REL_I:                rel_off = ptr1;
			AMD_M_BIT_DR, AMD_M_BIT_IR: rel_off = arg2;
			default:                    rel_off = 8'h00;
		endcase
		rel_target = next_pc + {{8{rel_off[7]}}, rel_off};
	end

endmodule

/* rtl/amd_addressing_decoder.sv */
module amd_addressing_decoder
	import amd_pkg::*;
#(
	parameter logic [15:0] RESET_PC = amd_pkg::AMD_RESET_PC
)
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Memory read port
	output logic                   mem_rd,
	output logic [15:0]            mem_addr,
	input  wire logic [7:0]        mem_rdata,
	input  wire logic              mem_rvalid,
	// Index registers from the datapath
	input  wire logic [7:0]        idx_x,
	input  wire logic [7:0]        idx_y,
	// Decoded instruction towards the datapath
	output logic                   res_valid,
	output amd_pkg::amd_res_s      res,
	input  wire logic              res_ack,
	input  wire logic              jump_taken
);

	// *****************************************************************
	// Sequencer states
	// *****************************************************************
	typedef enum logic [2:0] {
		AMD_S_OP   = 3'h0,
		AMD_S_ARG  = 3'h1,
		AMD_S_PTR  = 3'h2,
		AMD_S_EVAL = 3'h3,
		AMD_S_DONE = 3'h4
	} amd_state_e;

	amd_state_e  state_reg;
	amd_pre_e    pre_reg;
	amd_dec_s    dec_reg;
	amd_dec_s    dec_w;
	amd_mreq_s   mreq_reg;
	amd_res_s    res_reg;
	logic        res_valid_reg;
	logic [7:0]  opcode_reg;
	logic [7:0]  arg1_reg;
	logic [7:0]  arg2_reg;
	logic [7:0]  ptr1_reg;
	logic [7:0]  ptr2_reg;
	logic [1:0]  arg_cnt_reg;
	logic [1:0]  ptr_cnt_reg;
	logic [15:0] pc_reg;
	logic [7:0]  ptr_base;
	logic [7:0]  index_sel;
	logic [15:0] ea_w;
	logic [15:0] rel_w;
	logic        is_rel;
	logic        pre_take;

	// *****************************************************************
	// Prebyte recognition
	// *****************************************************************
	function automatic amd_pre_e pre_of(input logic [7:0] b);
		case (b)
			AMD_PRE_Y:    pre_of = AMD_P_Y;
			AMD_PRE_YIND: pre_of = AMD_P_YIND;
			AMD_PRE_IND:  pre_of = AMD_P_IND;
			default:      pre_of = AMD_P_NONE;
		endcase
	endfunction

	function automatic logic rel_mode(input amd_mode_e m);
		rel_mode = (m == AMD_M_REL_D) || (m == AMD_M_REL_I)
			|| (m == AMD_M_BIT_DR) || (m == AMD_M_BIT_IR);
	endfunction

	// *****************************************************************
	// Decoding and address arithmetic
	// *****************************************************************
	amd_mode_classify u_classify (
		.pre    (pre_reg),
		.opcode (mem_rdata),
		.dec    (dec_w)
	);

	// The pointer address is always the first byte after the opcode.
	assign ptr_base  = (arg_cnt_reg == 2'h0) ? mem_rdata : arg1_reg;
	assign index_sel = dec_reg.use_y ? idx_y : idx_x;
	assign is_rel    = rel_mode(dec_reg.mode);
	// A second prebyte is not taken and falls through as an opcode.
	assign pre_take  = (pre_of(mem_rdata) != AMD_P_NONE)
		&& (pre_reg == AMD_P_NONE);

	amd_ea_calc u_ea (
		.mode       (dec_reg.mode),
		.arg1       (arg1_reg),
		.arg2       (arg2_reg),
		.ptr1       (ptr1_reg),
		.ptr2       (ptr2_reg),
		.index      (index_sel),
		.next_pc    (pc_reg),
		.ea         (ea_w),
		.rel_target (rel_w)
	);

	// *****************************************************************
	// Fetch sequencing
	// *****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_reg   <= AMD_S_OP;
			dec_reg     <= '0;
			pc_reg      <= RESET_PC;
			mreq_reg.rd   <= 1'b1;
			mreq_reg.addr <= RESET_PC;
		end
		else
		begin
			case (state_reg)
				AMD_S_OP:
				begin
					if (mem_rvalid)
					begin
						pc_reg        <= pc_reg + AMD_PC_STEP;
						mreq_reg.addr <= pc_reg + AMD_PC_STEP;
						if (!pre_take)
						begin
							dec_reg <= dec_w;
							if (dec_w.n_bytes == 2'h0)
							begin
								mreq_reg.rd <= 1'b0;
								state_reg   <= AMD_S_EVAL;
							end
							else
								state_reg <= AMD_S_ARG;
						end
					end
				end
				AMD_S_ARG:
				begin
					if (mem_rvalid)
					begin
						pc_reg <= pc_reg + AMD_PC_STEP;
						if ((arg_cnt_reg + AMD_ONE) == dec_reg.n_bytes)
						begin
							if (dec_reg.ptr_bytes != 2'h0)
							begin
								mreq_reg.addr <= {AMD_PAGE0_HI, ptr_base};
								state_reg     <= AMD_S_PTR;
							end
							else
							begin
								mreq_reg.rd <= 1'b0;
								state_reg   <= AMD_S_EVAL;
							end
						end
						else
							mreq_reg.addr <= pc_reg + AMD_PC_STEP;
					end
				end
				AMD_S_PTR:
				begin
					if (mem_rvalid)
					begin
						mreq_reg.addr <= mreq_reg.addr + AMD_PC_STEP;
						if ((ptr_cnt_reg + AMD_ONE) == dec_reg.ptr_bytes)
						begin
							mreq_reg.rd <= 1'b0;
							state_reg   <= AMD_S_EVAL;
						end
					end
				end
				AMD_S_EVAL:
					state_reg <= AMD_S_DONE;
				AMD_S_DONE:
				begin
					if (res_ack)
					begin
						if (jump_taken)
						begin
							pc_reg        <= is_rel ? rel_w : res_reg.ea;
							mreq_reg.addr <= is_rel ? rel_w : res_reg.ea;
						end
						else
							mreq_reg.addr <= pc_reg;
						mreq_reg.rd <= 1'b1;
						state_reg   <= AMD_S_OP;
					end
				end
				default:
					state_reg <= AMD_S_OP;
			endcase
		end
	end

	// *****************************************************************
	// Prebyte register
	// *****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
			pre_reg <= AMD_P_NONE;
		else if ((state_reg == AMD_S_OP) && mem_rvalid && pre_take)
			pre_reg <= pre_of(mem_rdata);
		else if ((state_reg == AMD_S_DONE) && res_ack)
			pre_reg <= AMD_P_NONE;
	end

	// *****************************************************************
	// Instruction byte capture
	// *****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			opcode_reg  <= 8'h00;
			arg1_reg    <= 8'h00;
			arg2_reg    <= 8'h00;
			ptr1_reg    <= 8'h00;
			ptr2_reg    <= 8'h00;
			arg_cnt_reg <= 2'h0;
			ptr_cnt_reg <= 2'h0;
		end
		else if (mem_rvalid)
		begin
			case (state_reg)
				AMD_S_OP:
				begin
					arg_cnt_reg <= 2'h0;
					ptr_cnt_reg <= 2'h0;
					if (!pre_take)
						opcode_reg <= mem_rdata;
				end
				AMD_S_ARG:
				begin
					if (arg_cnt_reg == 2'h0)
						arg1_reg <= mem_rdata;
					else
						arg2_reg <= mem_rdata;
					arg_cnt_reg <= arg_cnt_reg + AMD_ONE;
				end
				AMD_S_PTR:
				begin
					if (ptr_cnt_reg == 2'h0)
						ptr1_reg <= mem_rdata;
					else
						ptr2_reg <= mem_rdata;
					ptr_cnt_reg <= ptr_cnt_reg + AMD_ONE;
				end
				default: ;
			endcase
		end
	end

	// *****************************************************************
	// Result register
	// *****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			res_reg       <= '0;
			res_valid_reg <= 1'b0;
		end
		else if (state_reg == AMD_S_EVAL)
		begin
			res_reg.mode       <= dec_reg.mode;
			res_reg.pre        <= pre_reg;
			res_reg.use_y      <= dec_reg.use_y;
			res_reg.is_long    <= dec_reg.is_long;
			res_reg.illegal    <= dec_reg.illegal;
			res_reg.opcode     <= opcode_reg;
			res_reg.length     <= 3'((pre_reg != AMD_P_NONE) ? 2 : 1)
				+ {1'b0, dec_reg.n_bytes};
			res_reg.operand    <= arg1_reg;
			res_reg.ea         <= ea_w;
			res_reg.rel_target <= rel_w;
			res_reg.next_pc    <= pc_reg;
			res_valid_reg      <= 1'b1;
		end
		else if ((state_reg == AMD_S_DONE) && res_ack)
			res_valid_reg <= 1'b0;
	end

	assign mem_rd    = mreq_reg.rd;
	assign mem_addr  = mreq_reg.addr;
	assign res_valid = res_valid_reg;
	assign res       = res_reg;

endmodule

/* bench/amd_addressing_decoder_assertions.sv */
module amd_dec_checker
	import amd_pkg::*;
#(
	parameter logic [15:0] RESET_PC = amd_pkg::AMD_RESET_PC
)
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Memory port
	input  wire logic              mem_rd,
	input  wire logic [15:0]       mem_addr,
	input  wire logic              mem_rvalid,
	// Result port
	input  wire logic              res_valid,
	input  wire amd_pkg::amd_res_s res,
	input  wire logic              res_ack,
	input  wire logic              jump_taken
);
	import amd_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	AST_RESET: assert property (disable iff (1'h0) srst |=> mem_rd
		&& mem_addr == RESET_PC && !res_valid)
		else $error("reset state wrong");
	AST_HOLD: assert property (mem_rd && !mem_rvalid |=> mem_rd
		&& $stable(mem_addr))
		else $error("read request not held");
	AST_ADV: assert property (mem_rd && mem_rvalid |=> !mem_rd
		|| mem_addr != $past(mem_addr))
		else $error("read address did not move");
	AST_RES_HOLD: assert property (res_valid && !res_ack |=> res_valid
		&& $stable(res))
		else $error("result changed before ack");
	AST_NEXT: assert property (res_valid && res_ack && !jump_taken
		|=> !res_valid && mem_rd && mem_addr == $past(res.next_pc))
		else $error("next fetch address wrong");
	AST_REL_JUMP: assert property (res_valid && res_ack && jump_taken
		&& res.mode inside {AMD_M_REL_D, AMD_M_REL_I}
		|=> mem_addr == $past(res.rel_target))
		else $error("relative jump target not fetched");
	AST_REL_SUM: assert property (res_valid && res.mode == AMD_M_REL_D
		|-> res.rel_target == res.next_pc
		+ {{8{res.operand[7]}}, res.operand})
		else $error("relative target sum wrong");
	AST_IMM_LEN: assert property (res_valid && res.mode == AMD_M_IMM
		|-> res.length == 3'h2)
		else $error("immediate length wrong");
	AST_PAGE0: assert property (res_valid && res.mode inside
		{AMD_M_DIR_S, AMD_M_IDX_0, AMD_M_IND_S}
		|-> res.ea[15:8] == AMD_PAGE0_HI)
		else $error("short address left page zero");
	AST_IDX_S: assert property (res_valid && res.mode inside
		{AMD_M_IDX_S, AMD_M_IIX_S} |-> res.ea <= 16'h01FE)
		else $error("short indexed address too high");
	AST_PRE_Y: assert property (res_valid && res.pre == AMD_P_Y
		&& !res.illegal |-> res.use_y)
		else $error("Y prebyte ignored");
	AST_SHORT: assert property (res_valid && res.pre == AMD_P_NONE
		&& res.opcode[7:4] == AMD_F_DIR_L
		&& res.opcode[3:0] >= AMD_SHORT_ONLY_MIN |-> res.illegal)
		else $error("long form accepted for short-only op");
endmodule

bind amd_addressing_decoder amd_dec_checker #(.RESET_PC(RESET_PC))
	u_amd_dec_checker (.clk(clk), .srst(srst), .mem_rd(mem_rd),
	.mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .res_valid(res_valid),
	.res(res), .res_ack(res_ack), .jump_taken(jump_taken));

/* bench/amd_mem_model.sv */
module amd_mem_model
(
	// Clock
	input  wire logic        clk,
	// Read port
	input  wire logic        mem_rd,
	input  wire logic [15:0] mem_addr,
	output logic [7:0]       mem_rdata,
	output logic             mem_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [256] = '{default: 8'h00};
	int         sd = 32'h1357;

	initial
	begin
		mem_rvalid = 1'h0;
		mem_rdata = 8'h00;
	end

	// Answers promptly or after random stalls; idle data keeps toggling.
	always @(negedge clk)
	begin
		if (mem_rd && $random(sd) % 3 != 0)
		begin
			mem_rvalid = 1'h1;
			mem_rdata = mem[mem_addr[7:0]];
		end
		else
		begin
			mem_rvalid = 1'h0;
			mem_rdata = ~mem_rdata;
		end
	end
endmodule

/* bench/addressing_mode_decoder_bench.sv */
module addressing_mode_decoder_bench
	import amd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [1:0] k;
		logic       tk;
		amd_res_s   r;
	} amd_exp_s;

	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic        res_ack = 1'h0;
	logic        jump_taken = 1'h0;
	logic        mem_rd, mem_rvalid, res_valid;
	logic [7:0]  mem_rdata, idx_x, idx_y, v, w, u;
	logic [15:0] mem_addr;
	amd_res_s    res;
	amd_exp_s    xm;
	amd_exp_s    q[$];
	int          seed = 32'ha0cf;
	int          errors = 0;
	int          checked = 0;
	int          pc = 0;
	int          t;

	initial
		forever #4 clk = ~clk;

	amd_addressing_decoder #(.RESET_PC(16'h0000)) u_amd_addressing_decoder (
		.clk(clk), .srst(srst), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .idx_x(idx_x),
		.idx_y(idx_y), .res_valid(res_valid), .res(res),
		.res_ack(res_ack), .jump_taken(jump_taken));

	amd_mem_model u_amd_mem_model (.clk(clk), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

	task automatic poke(input logic [15:0] a, input logic [7:0] b);
		u_amd_mem_model.mem[a[7:0]] = b;
	endtask

	task automatic put(input logic [7:0] b);
		poke(16'(pc), b);
		pc++;
	endtask

	// Places an instruction of n bytes and marks where it starts.
	task automatic ins(input int n, input logic [7:0] b0, b1, b2);
		t = pc;
		put(b0);
		if (n > 1)
			put(b1);
		if (n > 2)
			put(b2);
	endtask

	// Expected length zero means only the illegal flag is compared.
	task automatic note(input amd_mode_e m, input int st,
		input logic [15:0] e, input logic [1:0] k, input logic uy, il, tk);
		amd_exp_s x;
		x = '0;
		x.k = k;
		x.tk = tk;
		x.r.mode = m;
		x.r.length = 3'(pc - st);
		x.r.next_pc = 16'(pc);
		x.r.use_y = uy;
		x.r.illegal = il;
		x.r.ea = e;
		x.r.rel_target = e;
		x.r.operand = e[7:0];
		x.r.is_long = m inside {AMD_M_DIR_L, AMD_M_IDX_L, AMD_M_IND_L,
			AMD_M_IIX_L};
		x.r.opcode = u_amd_mem_model.mem[st[7:0]];
		if (x.r.opcode inside {AMD_PRE_Y, AMD_PRE_YIND, AMD_PRE_IND})
		begin
			x.r.pre = (x.r.opcode == AMD_PRE_Y) ? AMD_P_Y
				: (x.r.opcode == AMD_PRE_IND) ? AMD_P_IND : AMD_P_YIND;
			x.r.opcode = u_amd_mem_model.mem[8'(st + 1)];
		end
		q.push_back(x);
	endtask

	function automatic logic [15:0] pick(input amd_res_s r,
		input logic [1:0] k);
		return k == 2'h0 ? r.ea : k == 2'h1 ? r.rel_target
			: k == 2'h2 ? {8'h00, r.operand} : 16'h0000;
	endfunction

	task automatic stop_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(negedge clk)
	begin
		if (res_ack)
			res_ack = 1'h0;
		else if (res_valid && q.size() > 0 && $random(seed) % 2 != 0)
		begin
			res_ack = 1'h1;
			jump_taken = q[0].tk;
		end
	end

	always @(posedge clk)
	begin
		if (res_valid === 1'h1 && res_ack === 1'h1 && q.size() > 0)
		begin
			xm = q.pop_front();
			checked++;
			if (res.illegal !== xm.r.illegal || (xm.r.length != 0
				&& (res.length !== xm.r.length
				|| res.next_pc !== xm.r.next_pc
				|| res.use_y !== xm.r.use_y
				|| res.is_long !== xm.r.is_long
				|| res.opcode !== xm.r.opcode
				|| res.pre !== xm.r.pre
				|| (!xm.r.illegal && res.mode !== xm.r.mode)
				|| pick(res, xm.k) !== pick(xm.r, xm.k))))
			begin
				errors++;
				$display("wrong value at %0t: result %0d", $time, checked);
			end
			$display("test %0d done", checked);
		end
	end

	initial
	begin
		idx_x = 8'hFF;
		idx_y = 8'($random(seed));
		v = 8'($random(seed));
		w = 8'($random(seed));
		u = 8'($random(seed));
		ins(2, 8'h11, v, 8'h00);
		note(AMD_M_IMM, t, {8'h00, v}, 2'h2, 0, 0, 0);
		ins(2, 8'h2A, v, 8'h00);
		note(AMD_M_DIR_S, t, {8'h00, v}, 2'h0, 0, 0, 0);
		ins(3, 8'h39, v, w);
		note(AMD_M_DIR_L, t, {v, w}, 2'h0, 0, 0, 0);
		ins(1, 8'h44, 8'h00, 8'h00);
		note(AMD_M_IDX_0, t, {8'h00, idx_x}, 2'h0, 0, 0, 0);
		ins(2, 8'h55, 8'hFF, 8'h00);
		note(AMD_M_IDX_S, t, 16'h01FE, 2'h0, 0, 0, 0);
		ins(3, 8'h66, v, w);
		note(AMD_M_IDX_L, t, {v, w} + 16'(idx_x), 2'h0, 0, 0, 0);
		ins(3, 8'h90, 8'h55, v);
		note(AMD_M_IDX_S, t, 16'(v) + 16'(idx_y), 2'h0, 1, 0, 0);
		ins(2, 8'h90, 8'h01, 8'h00);
		note(AMD_M_INH, t, 16'h0000, 2'h3, 1, 0, 0);
		ins(3, 8'h92, 8'h22, 8'h80);
		poke(16'h0080, u);
		note(AMD_M_IND_S, t, {8'h00, u}, 2'h0, 0, 0, 0);
		ins(3, 8'h92, 8'h33, 8'h81);
		poke(16'h0081, v);
		poke(16'h0082, w);
		note(AMD_M_IND_L, t, {v, w}, 2'h0, 0, 0, 0);
		ins(3, 8'h92, 8'h55, 8'h83);
		poke(16'h0083, u);
		note(AMD_M_IIX_S, t, 16'(u) + 16'(idx_x), 2'h0, 0, 0, 0);
		ins(3, 8'h91, 8'h66, 8'h84);
		poke(16'h0084, w);
		poke(16'h0085, v);
		note(AMD_M_IIX_L, t, {w, v} + 16'(idx_y), 2'h0, 1, 0, 0);
		ins(2, 8'h77, 8'hFE, 8'h00);
		note(AMD_M_REL_D, t, 16'(t), 2'h1, 0, 0, 1);
		note(AMD_M_REL_D, t, 16'(t), 2'h1, 0, 0, 0);
		ins(3, 8'h92, 8'h77, 8'h86);
		poke(16'h0086, u);
		note(AMD_M_REL_I, t, 16'(pc) + {{8{u[7]}}, u}, 2'h1, 0, 0, 0);
		// A refused Y-indirect combination still reports the Y selection.
		ins(2, 8'h91, 8'h22, 8'h00);
		note(AMD_M_ILL, t, 16'h0000, 2'h3, 1, 1, 0);
		put(8'h3A);
		note(AMD_M_ILL, pc, 16'h0000, 2'h3, 0, 1, 0);
		repeat (10) @(posedge clk);
		@(negedge clk);
		srst = 1'h0;
		for (int i = 0; i < 3000 && q.size() > 0; i++)
			@(posedge clk);
		if (q.size() > 0)
		begin
			errors++;
			$display("wrong value at %0t: timed out", $time);
		end
		stop_test();
	end
endmodule
